// ### hdl/aeps_conv_ctrl.sv
// converter input selection, sequencing and serial return word
//
// Overview of operation
// - 8-bit results, timing from serial clock
// - one converter, eight inputs, one multiplexer
// - selector at input frame bits 2-4
// - selector 00x converts general input 0/1
// - selector 1xx converts a fixed pair
// - pair converted first member then second
// - selector 011 auto-selects from phase bits
// - phases differ: A family; equal: B family
// - phases filtered, captured each serial rise
// - phase A bit 2, B bit 3 returned
// - gain setting accepted at any time
// - general inputs are plain converter inputs
// - start during conversion is ignored
// - done flags each stand one return frame
// - source code in return bits 4-6
`timescale 1ns/1ps
module aeps_conv_ctrl (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic ce_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic quad_phase_a_raw,
  input wire logic quad_phase_b_raw,
  input wire logic filt_six_edge,
  input wire logic [7:0] adc_data,
  output logic [2:0] adc_mux_sel,
  output logic adc_sample,
  output logic adc_convert,
  output logic conv_busy,
  output logic [7:0] enc_gain
);

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [4:0] pins;
  logic sclk_prev_q;
  logic sclk_rise;
  logic ce_prev_q;
  logic ce_fall;
  logic ce_rise;
  logic ce_n_s;
  logic [1:0] phase_clean;

  assign pins = {quad_phase_b_raw, quad_phase_a_raw, mosi, ce_n, sclk};

  // two flops on every pin input
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= 5'h02;
      sync2_q <= 5'h02;
      sclk_prev_q <= 1'b0;
      ce_prev_q <= 1'b1;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      sclk_prev_q <= sync2_q[0];
      ce_prev_q <= sync2_q[1];
    end
  end

  assign ce_n_s = sync2_q[1];
  assign sclk_rise = sync2_q[0] & ~sclk_prev_q;
  assign ce_fall = ce_prev_q & ~ce_n_s;
  assign ce_rise = ~ce_prev_q & ce_n_s;

  // deglitch on serial clock edges
  aeps_deglitch u_deglitch (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .edge_en(sclk_rise),
    .six_edge(filt_six_edge),
    .raw(sync2_q[4:3]),
    .clean(phase_clean)
  );

  // ****************************************
  // serial shift registers and phase capture
  // ****************************************
  logic [15:0] in_sh_q;
  logic [15:0] in_sh_d;
  logic [15:0] out_sh_q;
  logic [15:0] out_sh_d;
  logic [1:0] phase_q;
  logic [1:0] phase_d;
  logic [7:0] gain_q;
  logic [7:0] gain_d;
  logic done1_q;
  logic done1_d;
  logic done2_q;
  logic done2_d;
  logic [7:0] result_q;
  logic [7:0] result_d;
  logic [2:0] src_q;
  logic [2:0] src_d;
  logic set_done1;
  logic set_done2;
  logic frame_done;
  aeps_pkg::aeps_ret_t ret_word;

  // return word from held result and captured phases
  always_comb begin
    ret_word = '0;
    ret_word.data = result_q;
    ret_word.src = src_q;
    ret_word.phase_a = phase_q[0];
    ret_word.phase_b = phase_q[1];
    ret_word.done1 = done1_q;
    ret_word.done2 = done2_q;
  end

  assign frame_done = ce_rise;

  // shift in on rise while selected, reload while deselected
  always_comb begin
    in_sh_d = in_sh_q;
    out_sh_d = out_sh_q;
    phase_d = phase_q;
    gain_d = gain_q;
    if (sclk_rise) begin
      phase_d = phase_clean;
    end
    if (ce_n_s) begin
      out_sh_d = ret_word;
    end else if (sclk_rise) begin
      in_sh_d = {in_sh_q[14:0], sync2_q[2]};
      out_sh_d = {out_sh_q[14:0], 1'b0};
    end
    if (frame_done && in_sh_q[aeps_pkg::CONFIG_BIT]) begin
      gain_d = in_sh_q[aeps_pkg::GAIN_MSB:aeps_pkg::GAIN_LSB];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      in_sh_q <= aeps_pkg::SHIFT_RESET;
      out_sh_q <= aeps_pkg::SHIFT_RESET;
      phase_q <= 2'h0;
      gain_q <= aeps_pkg::GAIN_RESET;
    end else begin
      in_sh_q <= in_sh_d;
      out_sh_q <= out_sh_d;
      phase_q <= phase_d;
      gain_q <= gain_d;
    end
  end

  // ****************************************
  // done flags: set by conversion end, cleared at the select fall of the next frame
  // ****************************************
  always_comb begin
    done1_d = done1_q;
    done2_d = done2_q;
    if (ce_fall) begin
      done1_d = 1'b0;
      done2_d = 1'b0;
    end
    if (set_done1) begin
      done1_d = 1'b1;
    end
    if (set_done2) begin
      done2_d = 1'b1;
    end
  end

  // ****************************************
  // request decode
  // ****************************************
  logic [2:0] req_sel;
  logic req_start;
  logic req_valid;
  aeps_pkg::aeps_job_t req_job;

  assign req_sel = in_sh_q[aeps_pkg::SEL_MSB:aeps_pkg::SEL_LSB];
  assign req_start = frame_done & ~in_sh_q[aeps_pkg::CONFIG_BIT]
    & in_sh_q[aeps_pkg::START_BIT];

  // selector to inputs, in conversion order
  always_comb begin
    req_job = '0;
    req_valid = 1'b1;
    case (req_sel)
      aeps_pkg::SEL_GEN0: req_job.first = aeps_pkg::SRC_GEN0;
      aeps_pkg::SEL_GEN1: req_job.first = aeps_pkg::SRC_GEN1;
      aeps_pkg::SEL_AUTO: begin
        case (phase_q)
          2'b01: req_job.first = aeps_pkg::SRC_ENC_A;
          2'b10: req_job.first = aeps_pkg::SRC_ENC_AINV;
          2'b11: req_job.first = aeps_pkg::SRC_ENC_B;
          default: req_job.first = aeps_pkg::SRC_ENC_BINV;
        endcase
      end
      aeps_pkg::SEL_A_B: begin
        req_job = {aeps_pkg::SRC_ENC_A, aeps_pkg::SRC_ENC_B, 1'b1};
      end
      aeps_pkg::SEL_A_AINV: begin
        req_job = {aeps_pkg::SRC_ENC_A, aeps_pkg::SRC_ENC_AINV, 1'b1};
      end
      aeps_pkg::SEL_B_BINV: begin
        req_job = {aeps_pkg::SRC_ENC_B, aeps_pkg::SRC_ENC_BINV, 1'b1};
      end
      aeps_pkg::SEL_DIRECT: begin
        req_job = {aeps_pkg::SRC_DIRECT_A, aeps_pkg::SRC_DIRECT_B, 1'b1};
      end
      default: req_valid = 1'b0;
    endcase
  end

  // ****************************************
  // conversion sequencer
  // ****************************************
  aeps_pkg::aeps_state_t state_q;
  aeps_pkg::aeps_state_t state_d;
  aeps_pkg::aeps_job_t job_q;
  aeps_pkg::aeps_job_t job_d;
  logic [5:0] edge_cnt_q;
  logic [5:0] edge_cnt_d;
  logic conv_end;

  assign conv_end = sclk_rise && (edge_cnt_q == 6'(aeps_pkg::CONV_EDGES - 1));

  // start, count edges, step to second member
  always_comb begin
    state_d = state_q;
    job_d = job_q;
    edge_cnt_d = edge_cnt_q;
    result_d = result_q;
    src_d = src_q;
    set_done1 = 1'b0;
    set_done2 = 1'b0;
    case (state_q)
      aeps_pkg::ST_IDLE: begin
        if (req_start && req_valid) begin
          job_d = req_job;
          edge_cnt_d = 6'h00;
          state_d = aeps_pkg::ST_CONV1;
        end
      end
      aeps_pkg::ST_CONV1: begin
        if (conv_end) begin
          result_d = adc_data;
          src_d = job_q.first;
          set_done1 = 1'b1;
          state_d = job_q.pair ? aeps_pkg::ST_WAIT2 : aeps_pkg::ST_IDLE;
        end else if (sclk_rise) begin
          edge_cnt_d = edge_cnt_q + 6'h01;
        end
      end
      aeps_pkg::ST_WAIT2: begin
        if (ce_fall) begin
          edge_cnt_d = 6'h00;
          state_d = aeps_pkg::ST_CONV2;
        end
      end
      aeps_pkg::ST_CONV2: begin
        if (conv_end) begin
          result_d = adc_data;
          src_d = job_q.second;
          set_done2 = 1'b1;
          state_d = aeps_pkg::ST_IDLE;
        end else if (sclk_rise) begin
          edge_cnt_d = edge_cnt_q + 6'h01;
        end
      end
      default: state_d = aeps_pkg::ST_IDLE;
    endcase
  end

  // a start while busy is dropped since only idle looks at it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= aeps_pkg::ST_IDLE;
      job_q <= '0;
      edge_cnt_q <= 6'h00;
      result_q <= 8'h00;
      src_q <= 3'h0;
      done1_q <= 1'b0;
      done2_q <= 1'b0;
    end else begin
      state_q <= state_d;
      job_q <= job_d;
      edge_cnt_q <= edge_cnt_d;
      result_q <= result_d;
      src_q <= src_d;
      done1_q <= done1_d;
      done2_q <= done2_d;
    end
  end

  // ****************************************
  // converter and pin outputs
  // ****************************************
  logic [2:0] mux_q;
  logic [2:0] mux_d;
  logic sample_q;
  logic sample_d;
  logic convert_q;
  logic convert_d;
  logic in_conv;

  assign in_conv = (state_q == aeps_pkg::ST_CONV1) || (state_q == aeps_pkg::ST_CONV2);

  // one multiplexer select for the shared converter
  always_comb begin
    mux_d = (state_q == aeps_pkg::ST_CONV2) ? job_q.second : job_q.first;
    sample_d = in_conv && (edge_cnt_q < 6'(aeps_pkg::SAMPLE_EDGES));
    convert_d = in_conv && !sample_d;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mux_q <= 3'h0;
      sample_q <= 1'b0;
      convert_q <= 1'b0;
    end else begin
      mux_q <= mux_d;
      sample_q <= sample_d;
      convert_q <= convert_d;
    end
  end

  assign adc_mux_sel = mux_q;
  assign adc_sample = sample_q;
  assign adc_convert = convert_q;
  assign conv_busy = (state_q != aeps_pkg::ST_IDLE);
  assign enc_gain = gain_q;
  assign miso = out_sh_q[15];
  assign miso_oe = ~ce_n_s;

endmodule

// ### include/aeps_pkg.sv
// package: constants, states and carriers for the converter input-select control
package aeps_pkg;

  // ****************************************
  // serial frame layout
  // ****************************************
  localparam int FRAME_BITS = 16;
  localparam int CONFIG_BIT = 0;
  localparam int START_BIT = 1;
  localparam int SEL_LSB = 2;
  localparam int SEL_MSB = 4;
  localparam int GAIN_LSB = 8;
  localparam int GAIN_MSB = 15;

  // ****************************************
  // timing counts in serial clock rising edges
  // ****************************************
  localparam int SAMPLE_EDGES = 15;
  localparam int CONV_EDGES = 32;
  localparam int FILT_SHORT = 3;
  localparam int FILT_LONG = 6;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] GAIN_RESET = 8'h00;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;

  // ****************************************
  // selector values
  // ****************************************
  localparam logic [2:0] SEL_GEN0 = 3'h0;
  localparam logic [2:0] SEL_GEN1 = 3'h1;
  localparam logic [2:0] SEL_AUTO = 3'h3;
  localparam logic [2:0] SEL_A_B = 3'h4;
  localparam logic [2:0] SEL_A_AINV = 3'h5;
  localparam logic [2:0] SEL_B_BINV = 3'h6;
  localparam logic [2:0] SEL_DIRECT = 3'h7;

  // ****************************************
  // source codes, also the multiplexer select
  // ****************************************
  localparam logic [2:0] SRC_GEN0 = 3'h0;
  localparam logic [2:0] SRC_GEN1 = 3'h1;
  localparam logic [2:0] SRC_DIRECT_A = 3'h2;
  localparam logic [2:0] SRC_DIRECT_B = 3'h3;
  localparam logic [2:0] SRC_ENC_A = 3'h4;
  localparam logic [2:0] SRC_ENC_B = 3'h5;
  localparam logic [2:0] SRC_ENC_AINV = 3'h6;
  localparam logic [2:0] SRC_ENC_BINV = 3'h7;

  // conversion sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV1 = 2'b01,
    ST_WAIT2 = 2'b10,
    ST_CONV2 = 2'b11
  } aeps_state_t;

  // one requested job: inputs in conversion order
  typedef struct packed {
    logic [2:0] first;
    logic [2:0] second;
    logic pair;
  } aeps_job_t;

  // normal-mode return word, bit 15 down to bit 0
  typedef struct packed {
    logic [7:0] data;
    logic rsvd;
    logic [2:0] src;
    logic phase_b;
    logic phase_a;
    logic done2;
    logic done1;
  } aeps_ret_t;

endpackage

// ### hdl/aeps_deglitch.sv
// two-bit deglitch filter counting serial clock edges
`timescale 1ns/1ps
module aeps_deglitch (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic edge_en,
  input wire logic six_edge,
  input wire logic [1:0] raw,
  output logic [1:0] clean
);

  logic [2:0] limit;

  // stability length: 3 or 6 edges
  assign limit = six_edge ? 3'(aeps_pkg::FILT_LONG) : 3'(aeps_pkg::FILT_SHORT);

  // ****************************************
  // one filter per phase bit
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_bit
      logic [2:0] cnt_q;
      logic [2:0] cnt_d;
      logic out_q;
      logic out_d;

      // count edges the raw level disagrees with the output
      always_comb begin
        cnt_d = cnt_q;
        out_d = out_q;
        if (raw[gi] == out_q) begin
          cnt_d = 3'h0;
        end else if (edge_en) begin
          if (cnt_q + 3'h1 >= limit) begin
            out_d = raw[gi];
            cnt_d = 3'h0;
          end else begin
            cnt_d = cnt_q + 3'h1;
          end
        end
      end

      always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          cnt_q <= 3'h0;
          out_q <= 1'b0;
        end else begin
          cnt_q <= cnt_d;
          out_q <= out_d;
        end
      end

      assign clean[gi] = out_q;
    end
  endgenerate

endmodule

// ### bench/aeps_conv_ctrl_props.sv
// checker: port timing relations of the converter input-select control
`timescale 1ns/1ps
module aeps_conv_ctrl_props (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic ce_n,
  input wire logic miso_oe,
  input wire logic [2:0] adc_mux_sel,
  input wire logic adc_sample,
  input wire logic adc_convert,
  input wire logic conv_busy,
  input wire logic [7:0] enc_gain
);
  // ****************************************
  // serial pin and conversion relations
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  // return pin is released while the select pin stays high
  a_oe_when_idle: assert property (ce_n [*4] |-> !miso_oe)
    else $error("return pin driven while deselected");
  a_oe_when_sel: assert property (!ce_n [*4] |-> miso_oe)
    else $error("return pin not driven while selected");
  // sample phase and convert phase never overlap
  a_phase_excl: assert property (!(adc_sample && adc_convert))
    else $error("sample and convert high together");
  // converter strobes are registered, so they follow the busy state by one cycle
  a_conv_busy: assert property ((adc_sample || adc_convert) |-> $past(conv_busy))
    else $error("converter active while not busy");
  // selected input holds through the whole convert phase
  a_sel_held: assert property (adc_convert |-> $stable(adc_mux_sel))
    else $error("input select moved during conversion");
  a_sample_then_conv: assert property ($fell(adc_sample) |-> adc_convert)
    else $error("sample phase not followed by convert phase");
  // with the serial clock still, conversion progress stands still
  a_sclk_paces: assert property ($stable(sclk) [*8] |-> $stable(adc_convert))
    else $error("conversion advanced without serial clock");
  a_gain_between: assert property (!$stable(enc_gain) |-> ce_n)
    else $error("gain changed inside a frame");
  a_accept_between: assert property ($rose(conv_busy) |-> ce_n)
    else $error("job accepted inside a frame");

  // main scenarios reached
  c_job_start: cover property ($rose(conv_busy));
  c_pair_second: cover property ($rose(adc_sample) && adc_mux_sel == 3'h6);
  c_gain_write: cover property ($changed(enc_gain));
endmodule

// ### bench/aeps_host.sv
// host model: serial master that sends and receives 16-bit frames
`timescale 1ns/1ps
module aeps_host (
  output logic sclk,
  output logic ce_n,
  output logic mosi,
  input wire logic miso
);
  // clock idles low, select idles high, data held low between frames
  initial begin
    sclk = 1'b0;
    ce_n = 1'b1;
    mosi = 1'b0;
  end

  // one frame, msb first; return bit taken at each rising serial clock
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    integer i;
    ce_n = 1'b0;
    for (i = 15; i >= 0; i--) begin
      mosi = tx[i];
      #160;
      sclk = 1'b1;
      rx[i] = miso;
      #160;
      sclk = 1'b0;
    end
    #160;
    ce_n = 1'b1;
    mosi = 1'b0;
    #1280;
  endtask
endmodule

// ### bench/aeps_conv_ctrl_tb.sv
// testbench: serial frames start conversions, return words are checked
`timescale 1ns/1ps
module aeps_conv_ctrl_tb;
  logic ref_clk, reset_n, sclk, ce_n, mosi, miso, miso_oe;
  logic miso_pin;
  logic quad_phase_a_raw, quad_phase_b_raw, filt_six_edge;
  logic [7:0] adc_data;
  logic [2:0] adc_mux_sel;
  logic adc_sample, adc_convert, conv_busy;
  logic [7:0] enc_gain;
  aeps_pkg::aeps_ret_t rx;
  int errors = 0;
  int compares = 0;

  aeps_conv_ctrl dut_u (.ref_clk, .reset_n, .sclk, .ce_n, .mosi, .miso, .miso_oe,
    .quad_phase_a_raw, .quad_phase_b_raw, .filt_six_edge, .adc_data, .adc_mux_sel,
    .adc_sample, .adc_convert, .conv_busy, .enc_gain);
  aeps_host host_u (.sclk, .ce_n, .mosi, .miso(miso_pin));

  // a released return pin shows the wrong level, so late enables are caught
  assign miso_pin = miso_oe ? miso : ~miso;

  // ****************************************
  // clock, converter stand-in, helpers
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // converter result tags the low bits with the selected input
  always @(negedge ref_clk) adc_data <= {5'h15, adc_mux_sel};

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic frame(input logic [15:0] tx);
    logic [15:0] r;
    host_u.xfer(tx, r);
    rx = r;
  endtask

  // poll idle frames until flag b appears, then judge the word
  task automatic poll(input int b, input logic [2:0] s);
    int n;
    n = 0;
    do begin
      frame(16'h0000);
      n++;
    end while (rx[b] !== 1'b1 && n < 8);
    check({3'h0, rx.done1, rx.done2, rx.src, rx.data},
      {3'h0, b == 0, b == 1, s, 5'h15, s});
    if (rx[b] !== 1'b1) final_report;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // undefined selector and config frame never start a job
  task automatic run_refused;
    frame({11'h000, 3'h2, 2'b10});
    check({15'h0000, conv_busy}, 16'h0000);
    frame(16'h5A03);
    check({7'h00, conv_busy, enc_gain}, 16'h005A);
  endtask

  // one job; a start arrives while it is busy, a gain write once its first conversion has ended
  task automatic run_conv(input logic [2:0] sel, input logic [1:0] ph, input logic [2:0] s1,
      input logic [2:0] s2, input logic pair);
    quad_phase_a_raw = ph[0];
    quad_phase_b_raw = ph[1];
    filt_six_edge = ph[0];
    frame(16'h0000);
    frame({11'h000, sel, 2'b10});
    check({14'h0000, rx.phase_b, rx.phase_a}, {14'h0000, ph});
    check({11'h000, adc_mux_sel, adc_sample, adc_convert}, {11'h000, s1, 2'b10});
    frame({11'h000, ~sel, 2'b10});
    check({14'h0000, adc_sample, adc_convert}, 16'h0001);
    frame({sel, 5'h0A, 3'h0, ~sel, 2'b11});
    check({8'h00, enc_gain}, {8'h00, sel, 5'h0A});
    poll(0, s1);
    // host joins the returned phase state with the fraction
    check({6'h00, rx.phase_b, rx.phase_a, rx.data}, {6'h00, ph, 5'h15, s1});
    if (pair) poll(1, s2);
    frame(16'h0000);
    check({13'h0000, conv_busy, rx.done2, rx.done1}, 16'h0000);
  endtask

  // main sequence
  initial begin
    reset_n = 1'b0;
    quad_phase_a_raw = 1'b0;
    quad_phase_b_raw = 1'b0;
    filt_six_edge = 1'b0;
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    check({enc_gain, 5'h00, conv_busy, miso_oe, miso}, 16'h0000);
    repeat (3) @(negedge ref_clk);
    run_refused;
    run_conv(aeps_pkg::SEL_GEN0, 2'b00, aeps_pkg::SRC_GEN0, 3'h0, 1'b0);
    run_conv(aeps_pkg::SEL_GEN1, 2'b11, aeps_pkg::SRC_GEN1, 3'h0, 1'b0);
    run_conv(aeps_pkg::SEL_AUTO, 2'b01, aeps_pkg::SRC_ENC_A, 3'h0, 1'b0);
    run_conv(aeps_pkg::SEL_AUTO, 2'b10, aeps_pkg::SRC_ENC_AINV, 3'h0, 1'b0);
    run_conv(aeps_pkg::SEL_AUTO, 2'b11, aeps_pkg::SRC_ENC_B, 3'h0, 1'b0);
    run_conv(aeps_pkg::SEL_AUTO, 2'b00, aeps_pkg::SRC_ENC_BINV, 3'h0, 1'b0);
    run_conv(aeps_pkg::SEL_A_B, 2'b01, aeps_pkg::SRC_ENC_A, aeps_pkg::SRC_ENC_B, 1'b1);
    run_conv(aeps_pkg::SEL_A_AINV, 2'b10, aeps_pkg::SRC_ENC_A, aeps_pkg::SRC_ENC_AINV, 1'b1);
    run_conv(aeps_pkg::SEL_B_BINV, 2'b00, aeps_pkg::SRC_ENC_B, aeps_pkg::SRC_ENC_BINV, 1'b1);
    run_conv(aeps_pkg::SEL_DIRECT, 2'b11, aeps_pkg::SRC_DIRECT_A, aeps_pkg::SRC_DIRECT_B, 1'b1);
    final_report;
  end
endmodule

bind aeps_conv_ctrl aeps_conv_ctrl_props props_u (.ref_clk, .reset_n, .sclk, .ce_n,
  .miso_oe, .adc_mux_sel, .adc_sample, .adc_convert, .conv_busy, .enc_gain);
